// >>> test/fci_ctrl_sva.sv
// Purpose: pin protocol checks for fci_ctrl
// Assumes: one clock, reset active low
// Notes: bound into every fci_ctrl
module fci_ctrl_sva (
   input wire logic CLK, // clock
   input wire logic RST_B, // reset, active low
   input wire logic FL_CE_N, // chip select
   input wire logic FL_OE_N, // output drive
   input wire logic FL_WE_N, // write strobe
   input wire logic FL_DQ_OE, // data drive
   input wire logic POWERDOWN_RESET_N // power-down
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge CLK);
   endclocking
   default disable iff (!RST_B);
   a_we_one_cycle: assert property ($fell(FL_WE_N) |=> FL_WE_N)
      else $error("we long");
   a_we_inside_ce: assert property ($fell(FL_WE_N) |-> !$past(FL_CE_N) && FL_DQ_OE)
      else $error("we no ce");
   a_write_no_oe: assert property (!FL_WE_N |-> FL_OE_N)
      else $error("oe in write");
   a_read_released: assert property (!FL_OE_N |-> !FL_DQ_OE && !FL_CE_N)
      else $error("dq in read");
   a_oe_six: assert property ($fell(FL_OE_N) |-> !FL_OE_N [*6] ##1 FL_OE_N)
      else $error("oe length");
   a_oe_relatch: assert property ($rose(FL_OE_N) |-> FL_OE_N [*4])
      else $error("oe relatch");
   a_pd_quiet: assert property (!POWERDOWN_RESET_N |-> FL_CE_N && FL_WE_N)
      else $error("pd active");
   a_ce_release: assert property ($rose(FL_CE_N) |-> !FL_DQ_OE && FL_OE_N)
      else $error("ce release");
   cover property ($fell(FL_WE_N));
   cover property ($fell(FL_OE_N));
   cover property ($fell(POWERDOWN_RESET_N));
endmodule : fci_ctrl_sva

bind fci_ctrl fci_ctrl_sva u_sva (.CLK(CLK), .RST_B(RST_B), .FL_CE_N(FL_CE_N),
   .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N), .FL_DQ_OE(FL_DQ_OE),
   .POWERDOWN_RESET_N(POWERDOWN_RESET_N));

// >>> test/fci_ctrl_test.sv
// Purpose: bench for fci_ctrl
// Assumes: 25 MHz clock
// Notes: flash model is fast
`include "fci_regs.svh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin error_cnt++; \
   $display("[ERR] %s exp %h got %h", n, e, s); end end
module fci_ctrl_test;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [3:0] op; logic [16:0] a; logic [1:0] m; logic [7:0] r;} fci_row_t;
   localparam logic [7:0] MFG = 8'h5A; // arbitrary
   localparam logic [7:0] DEV = 8'hC3; // arbitrary
   fci_row_t rows [6] = '{'{4'h2, 17'h0, 2'h1, 8'h00}, '{4'h4, 17'h0, 2'h2, 8'h00},
      '{4'h9, 17'h0, 2'h2, MFG}, '{4'h9, 17'h1, 2'h2, DEV}, '{4'h1, 17'h0, 2'h0, 8'h00},
      '{4'h9, 17'h3, 2'h0, 8'hFF}};
   logic CLK = 1'b0, RST_B = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, err = 1'b0;
   logic [7:0] REG_ADDR = 8'h00;
   logic [31:0] REG_WDATA = 32'h0, REG_RDATA, d;
   logic [16:0] FL_ADDR;
   logic [7:0] FL_DQ_OUT, FL_DQ_IN, fl_dq;
   logic FL_DQ_OE, FL_CE_N, FL_OE_N, FL_WE_N, POWERDOWN_RESET_N, PROGRAM_SUPPLY_HIGH_LEVEL;
   int error_cnt = 0, compares = 0;
   always #20 CLK = ~CLK;
   assign FL_DQ_IN = FL_DQ_OE ? FL_DQ_OUT : fl_dq;
   fci_ctrl uut (.CLK(CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .FL_ADDR(FL_ADDR),
      .FL_DQ_OUT(FL_DQ_OUT), .FL_DQ_OE(FL_DQ_OE), .FL_DQ_IN(FL_DQ_IN), .FL_CE_N(FL_CE_N),
      .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N), .POWERDOWN_RESET_N(POWERDOWN_RESET_N),
      .PROGRAM_SUPPLY_HIGH_LEVEL(PROGRAM_SUPPLY_HIGH_LEVEL));
   fci_flash_model #(.MFG_ID(MFG), .DEV_ID(DEV)) flash (.ce_n(FL_CE_N), .oe_n(FL_OE_N),
      .we_n(FL_WE_N), .addr(FL_ADDR), .din(FL_DQ_OUT), .rp_n(POWERDOWN_RESET_N),
      .vpp(PROGRAM_SUPPLY_HIGH_LEVEL), .err(err), .dq(fl_dq));
   task automatic print_verdict();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge CLK);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= v;
      @(posedge CLK);
      REG_WR <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge CLK);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge CLK);
      REG_RD <= 1'b0;
      #1 d = REG_RDATA;
   endtask : rd
   task automatic wt();
      int i;
      for (i = 0; i < 400; i++) begin
         rd(`FCI_REG_STATUS);
         if (d[0] === 1'b0)
            break;
      end
      if (i == 400) begin
         error_cnt++;
         print_verdict();
      end
   endtask : wt
   task automatic op(input logic [3:0] c);
      wr(`FCI_REG_CMD, {28'h0, c});
      wt();
   endtask : op
   initial begin
      repeat (4) @(posedge CLK);
      RST_B <= 1'b1;
      foreach (rows[k]) begin
         wr(`FCI_REG_ADDR, {15'h0, rows[k].a});
         op(rows[k].op);
         `CHK("mode", rows[k].m, d[4:3])
         if (rows[k].op == 4'h9) begin
            rd(`FCI_REG_RDATA);
            `CHK("rdata", rows[k].r, d[7:0])
         end
      end
      op(4'h5);
      `CHK("refused", 1'b1, d[1])
      wr(`FCI_REG_STATUS, 32'h2);
      wr(`FCI_REG_CTRL, 32'h2);
      wr(`FCI_REG_ADDR, 32'h5);
      wr(`FCI_REG_WDATA, 32'h3C);
      op(4'h6);
      `CHK("prog", 10'h201, {d[15:8], d[4:3]})
      op(4'h1);
      op(4'h9);
      rd(`FCI_REG_RDATA);
      `CHK("byte", 8'h3C, d[7:0])
      op(4'h5);
      `CHK("erase", 11'h401, {d[15:8], d[1], d[4:3]})
      @(posedge CLK) err <= 1'b1;
      op(4'h5);
      `CHK("efail", 8'hA0, d[15:8])
      @(posedge CLK) err <= 1'b0;
      op(4'h2);
      op(4'h9);
      `CHK("cleared", 8'h80, d[15:8])
      wr(`FCI_REG_CTRL, 32'h3);
      repeat (4) @(posedge CLK);
      `CHK("pd", 1'b0, POWERDOWN_RESET_N)
      wr(`FCI_REG_CMD, 32'h1);
      rd(`FCI_REG_STATUS);
      `CHK("pd refuse", 1'b1, d[1])
      wr(`FCI_REG_CTRL, 32'h2);
      wt();
      op(4'h9);
      rd(`FCI_REG_RDATA);
      `CHK("wake", 8'hFF, d[7:0])
      @(posedge CLK) RST_B <= 1'b0;
      repeat (4) @(posedge CLK);
      `CHK("pins", 4'hF, {FL_CE_N, FL_OE_N, FL_WE_N, POWERDOWN_RESET_N})
      RST_B <= 1'b1;
      rd(`FCI_REG_STATUS);
      `CHK("status", 32'h0, d)
      rd(8'h20);
      `CHK("unmapped", 32'h0, d)
      print_verdict();
   end
endmodule : fci_ctrl_test

// >>> test/fci_flash_model.sv
// Purpose: flash device model
// Assumes: pins only
// Notes: busy times shortened to keep runs short
module fci_flash_model #(
   parameter logic [7:0] MFG_ID = 8'h5A, // arbitrary
   parameter logic [7:0] DEV_ID = 8'hC3 // arbitrary
) (
   input wire logic ce_n, // chip select
   input wire logic oe_n, // output drive
   input wire logic we_n, // write strobe
   input wire logic [16:0] addr, // address
   input wire logic [7:0] din, // data from controller
   input wire logic rp_n, // power-down
   input wire logic vpp, // high program supply
   input wire logic err, // make the next erase fail
   output logic [7:0] dq // data to controller
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [16];
   logic [7:0] sr = 8'h80;
   logic [7:0] srl = 8'h00, last = 8'h00, pend = 8'h00;
   logic [7:0] val;
   logic [1:0] mode = 2'h0;
   logic en;
   int cnt = 0;
   initial foreach (mem[i]) mem[i] = 8'hFF;
   assign en = rp_n && !ce_n && !oe_n && we_n;
   assign val = mode == 2'h1 ? srl : mode == 2'h2 ? (addr[0] ? DEV_ID : MFG_ID) : mem[addr[3:0]];
   // a released line shows the inverse, not a held value
   assign dq = en ? val : ~last;
   always @(negedge en) last = val;
   // status latched as the read opens
   always @(posedge en) srl = sr;
   // ready when the timer runs out
   always #40 begin
      if (cnt == 1)
         sr[7] = 1'b1;
      if (cnt > 0)
         cnt--;
   end
   // power-down aborts and returns to array
   always @(negedge rp_n) begin
      mode = 2'h0;
      pend = 8'h00;
      cnt = 0;
      sr[7] = 1'b1;
   end
   // address and data taken at strobe rise
   always @(posedge we_n) begin
      if (rp_n && !ce_n) begin
         if (pend == 8'h20 || pend == 8'h40) begin
            mode = 2'h1;
            sr[7] = 1'b0;
            cnt = 5;
            if (pend == 8'h40)
               mem[addr[3:0]] = mem[addr[3:0]] & din;
            else if (din != 8'hD0)
               sr[5:4] = 2'b11;
            else if (!vpp)
               sr[5:3] = 3'b101;
            else begin
               sr[5] = err;
               cnt = 20;
               mem[addr[3:0]] = 8'hFF;
            end
            pend = 8'h00;
         end else begin
            case (din)
               8'hFF: mode = 2'h0;
               8'h50: sr[5:3] = 3'h0;
               8'h90: mode = 2'h2;
               8'h70, 8'h20, 8'h40, 8'h10: mode = 2'h1;
               default: ;
            endcase
            pend = din == 8'h10 ? 8'h40 : din;
         end
      end
   end
endmodule : fci_flash_model

// >>> verilog/fci_bus_cycle.sv
// Purpose: one asynchronous bus cycle (write or read) on the flash pins
// Assumes: dq_in is already synchronised; start only while idle
// Notes: done pulses one cycle after recovery
`include "fci_regs.svh"

module fci_bus_cycle (
   input wire logic clk, // controller clock
   input wire logic rst_b, // async reset, active low
   input wire logic start, // begin a cycle
   input wire logic is_write, // 1 write, 0 read
   input wire logic [16:0] addr, // flash address
   input wire logic [7:0] wdata, // byte to write
   input wire logic [7:0] dq_in, // synchronised data pins
   output logic done, // cycle finished pulse
   output logic [7:0] rdata, // byte read
   output fci_pkg::fci_pins_t pins // registered pin drive
);
   localparam int PER = `FCI_CLK_PERIOD_NS;
   localparam int WP_CYC = (`FCI_T_WP_NS + PER - 1) / PER;
   localparam int WPH_CYC = (`FCI_T_WPH_NS + PER - 1) / PER;
   localparam int ACC_CYC = (`FCI_T_ACC_NS + PER - 1) / PER;
   localparam int HZ_CYC = (`FCI_T_HZ_NS + PER - 1) / PER;

   fci_pkg::fci_cy_state_t state, next_state;
   fci_pkg::fci_pins_t next_pins;
   logic [3:0] cnt, next_cnt;
   logic wr, next_wr;
   logic next_done;
   logic [7:0] next_rdata;

   always_comb begin
      next_state = state;
      next_pins = pins;
      next_cnt = cnt;
      next_wr = wr;
      next_done = 1'b0;
      next_rdata = rdata;
      case (state)
         fci_pkg::FCI_CY_IDLE: begin
            if (start) begin
               next_pins.addr = addr;
               next_pins.dq_out = wdata;
               next_pins.dq_oe = is_write;
               next_pins.ce_n = 1'b0;
               next_pins.oe_n = 1'b1;
               next_pins.we_n = 1'b1;
               next_wr = is_write;
               next_state = fci_pkg::FCI_CY_SETUP;
            end
         end
         fci_pkg::FCI_CY_SETUP: begin
            // R06 address and data stand
            if (wr) begin
               next_pins.we_n = 1'b0;
               next_cnt = 4'(WP_CYC - 1);
            end else begin
               // two extra cycles cover the data synchroniser
               next_pins.oe_n = 1'b0;
               next_cnt = 4'(ACC_CYC + 1);
            end
            next_state = fci_pkg::FCI_CY_STROBE;
         end
         fci_pkg::FCI_CY_STROBE: begin
            if (cnt != 4'h0) begin
               next_cnt = cnt - 4'h1;
            end else begin
               if (!wr) begin
                  next_rdata = dq_in;
               end
               // R10 strobe returns high
               next_pins.we_n = 1'b1;
               next_pins.oe_n = 1'b1;
               next_cnt = wr ? 4'(WPH_CYC) : 4'(HZ_CYC);
               next_state = fci_pkg::FCI_CY_RECOVER;
            end
         end
         fci_pkg::FCI_CY_RECOVER: begin
            // data held past the rising strobe, read bus left to float
            if (cnt != 4'h0) begin
               next_cnt = cnt - 4'h1;
            end else begin
               next_pins.ce_n = 1'b1;
               next_pins.dq_oe = 1'b0;
               next_done = 1'b1;
               next_state = fci_pkg::FCI_CY_IDLE;
            end
         end
         default: begin
            next_state = fci_pkg::FCI_CY_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= fci_pkg::FCI_CY_IDLE;
         pins <= '{17'h00000, 8'h00, 1'b0, 1'b1, 1'b1, 1'b1};
         cnt <= 4'h0;
         wr <= 1'b0;
         done <= 1'b0;
         rdata <= 8'h00;
      end else begin
         state <= next_state;
         pins <= next_pins;
         cnt <= next_cnt;
         wr <= next_wr;
         done <= next_done;
         rdata <= next_rdata;
      end
   end

endmodule : fci_bus_cycle

// >>> verilog/fci_ctrl.sv
// Purpose: host-side controller that drives a boot-block flash through its pins
// Assumes: 25 MHz clock; software on a plain register port
// Notes: erase and program poll until ready; no timeout
//
// Behaviour
// R01: device reads array after power-up or wake
// R02: read with select and drive low
// R03: output drive high keeps pins floating
// R04: deselected device floats its outputs
// R05: power-down ignores all other inputs
// R06: commands take one or two writes
// R07: byte FF selects array reads
// R08: device keeps an eight-bit status byte
// R09: byte 70 selects status reads
// R10: strobe high again before next read
// R11: fail bits stay until clear status
// R12: clear supply-low before program or erase
// R13: erase is 20 then D0, same block
// R14: erase needs high program supply level
// R15: after erase, reads return status
// R16: ready bit and erase-fail show outcome
// R17: clear status after an erase error
// R18: byte 90 gives identification codes
// R19: high-voltage identification not used here
// R20: identification mode lasts until next command
// R21: program is 40 then address and data
// R22: B0 suspends erase, D0 resumes
// R23: status bit layout seven down to three
// R24: bad erase confirm sets both fail bits
//
// The register addresses and strobed register access were left to the implementer.
`include "fci_regs.svh"

module fci_ctrl (
   input wire logic CLK, // 25 MHz clock
   input wire logic RST_B, // async reset, active low
   input wire logic [7:0] REG_ADDR, // register byte address
   input wire logic [31:0] REG_WDATA, // register write data
   input wire logic REG_WR, // write strobe
   input wire logic REG_RD, // read strobe
   output logic [31:0] REG_RDATA, // read data, cycle after strobe
   output logic [16:0] FL_ADDR, // flash address pins
   output logic [7:0] FL_DQ_OUT, // flash data out
   output logic FL_DQ_OE, // flash data drive enable
   input wire logic [7:0] FL_DQ_IN, // flash data in
   output logic FL_CE_N, // chip select, active low
   output logic FL_OE_N, // output drive, active low
   output logic FL_WE_N, // write strobe, active low
   output logic POWERDOWN_RESET_N, // power-down, active low
   output logic PROGRAM_SUPPLY_HIGH_LEVEL // request high program supply
);
   localparam int WAKE_CYC = (`FCI_T_WAKE_NS + `FCI_CLK_PERIOD_NS - 1) / `FCI_CLK_PERIOD_NS;

   logic [7:0] dq_meta, dq_sync;
   logic cyc_done;
   logic [7:0] cyc_rdata;
   fci_pkg::fci_pins_t pins;

   logic [16:0] addr_r, next_addr_r;
   logic [7:0] wdata_r, next_wdata_r;
   logic pwrdn, next_pwrdn;
   logic supply, next_supply;
   logic [31:0] next_rdata_bus;

   fci_pkg::fci_sq_state_t sq, next_sq;
   fci_pkg::fci_mode_t mode, next_mode;
   logic [3:0] op, next_op;
   logic cyc_start, next_cyc_start;
   logic cyc_write, next_cyc_write;
   logic [7:0] cyc_data, next_cyc_data;
   logic [16:0] cyc_addr, next_cyc_addr;
   logic [7:0] dev_status, next_dev_status;
   logic [7:0] rbyte, next_rbyte;
   logic refused, next_refused;
   logic supply_lock, next_supply_lock;
   logic [4:0] wake_cnt, next_wake_cnt;
   logic rp_n, next_rp_n;
   logic cmd_wr, op_valid, needs_supply;

   // data pins are asynchronous to CLK
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         dq_meta <= 8'h00;
         dq_sync <= 8'h00;
      end else begin
         dq_meta <= FL_DQ_IN;
         dq_sync <= dq_meta;
      end
   end

   fci_bus_cycle u_cycle (
      .clk(CLK),
      .rst_b(RST_B),
      .start(cyc_start),
      .is_write(cyc_write),
      .addr(cyc_addr),
      .wdata(cyc_data),
      .dq_in(dq_sync),
      .done(cyc_done),
      .rdata(cyc_rdata),
      .pins(pins)
   );

   assign FL_ADDR = pins.addr;
   assign FL_DQ_OUT = pins.dq_out;
   assign FL_DQ_OE = pins.dq_oe;
   assign FL_CE_N = pins.ce_n;
   assign FL_OE_N = pins.oe_n;
   assign FL_WE_N = pins.we_n;
   assign POWERDOWN_RESET_N = rp_n;
   assign PROGRAM_SUPPLY_HIGH_LEVEL = supply;

   assign cmd_wr = REG_WR && (REG_ADDR == `FCI_REG_CMD);
   assign op_valid = (REG_WDATA[3:0] >= `FCI_OP_READ_ARRAY) && (REG_WDATA[3:0] <= `FCI_OP_READ);
   assign needs_supply = (REG_WDATA[3:0] == `FCI_OP_ERASE) ||
                         (REG_WDATA[3:0] == `FCI_OP_PROGRAM);

   // software registers
   always_comb begin
      next_addr_r = addr_r;
      next_wdata_r = wdata_r;
      next_pwrdn = pwrdn;
      next_supply = supply;
      next_rdata_bus = 32'h00000000;
      if (REG_WR) begin
         case (REG_ADDR)
            `FCI_REG_ADDR: next_addr_r = REG_WDATA[16:0];
            `FCI_REG_WDATA: next_wdata_r = REG_WDATA[7:0];
            `FCI_REG_CTRL: begin
               next_pwrdn = REG_WDATA[`FCI_CTRL_PWRDN];
               next_supply = REG_WDATA[`FCI_CTRL_SUPPLY];
            end
            default: begin
            end
         endcase
      end
      if (REG_RD) begin
         case (REG_ADDR)
            `FCI_REG_ADDR: next_rdata_bus = {15'h0000, addr_r};
            `FCI_REG_WDATA: next_rdata_bus = {24'h000000, wdata_r};
            `FCI_REG_CTRL: next_rdata_bus = {30'h00000000, supply, pwrdn};
            `FCI_REG_STATUS: begin
               next_rdata_bus[`FCI_ST_BUSY] = (sq != fci_pkg::FCI_SQ_IDLE);
               next_rdata_bus[`FCI_ST_REFUSED] = refused;
               next_rdata_bus[`FCI_ST_SUPPLY_LOCK] = supply_lock;
               next_rdata_bus[`FCI_ST_MODE_HI:`FCI_ST_MODE_LO] = mode;
               next_rdata_bus[`FCI_ST_DEV_HI:`FCI_ST_DEV_LO] = dev_status;
            end
            `FCI_REG_RDATA: next_rdata_bus = {24'h000000, rbyte};
            default: next_rdata_bus = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         addr_r <= `FCI_RST_ADDR;
         wdata_r <= `FCI_RST_WDATA;
         pwrdn <= 1'b0;
         supply <= 1'b0;
         REG_RDATA <= 32'h00000000;
      end else begin
         addr_r <= next_addr_r;
         wdata_r <= next_wdata_r;
         pwrdn <= next_pwrdn;
         supply <= next_supply;
         REG_RDATA <= next_rdata_bus;
      end
   end

   // command sequencer
   always_comb begin
      next_sq = sq;
      next_mode = mode;
      next_op = op;
      next_cyc_start = 1'b0;
      next_cyc_write = cyc_write;
      next_cyc_data = cyc_data;
      next_cyc_addr = cyc_addr;
      next_dev_status = dev_status;
      next_rbyte = rbyte;
      next_refused = refused;
      next_supply_lock = supply_lock;
      next_wake_cnt = wake_cnt;
      next_rp_n = rp_n;
      // a refusal in the same cycle as the clear keeps the flag set
      if (REG_WR && (REG_ADDR == `FCI_REG_STATUS) && REG_WDATA[`FCI_ST_REFUSED]) begin
         next_refused = 1'b0;
      end
      // commands are refused while anything is in progress
      if (cmd_wr && (sq != fci_pkg::FCI_SQ_IDLE)) begin
         next_refused = 1'b1;
      end
      case (sq)
         fci_pkg::FCI_SQ_IDLE: begin
            if (pwrdn) begin
               // R05 hold device in power-down
               next_rp_n = 1'b0;
               next_sq = fci_pkg::FCI_SQ_PD;
               if (cmd_wr) begin
                  next_refused = 1'b1;
               end
            end else if (cmd_wr) begin
               // R12 R14 no program or erase while locked or unpowered
               if (!op_valid || (needs_supply && (supply_lock || !supply))) begin
                  next_refused = 1'b1;
               end else begin
                  next_op = REG_WDATA[3:0];
                  next_cyc_start = 1'b1;
                  next_cyc_write = 1'b1;
                  next_cyc_addr = addr_r;
                  next_sq = fci_pkg::FCI_SQ_FIRST;
                  case (REG_WDATA[3:0])
                     // R07 array reads
                     `FCI_OP_READ_ARRAY: next_cyc_data = `FCI_CMD_READ_ARRAY;
                     // R09 status reads
                     `FCI_OP_READ_STATUS: next_cyc_data = `FCI_CMD_READ_STATUS;
                     // R11 fail bits cleared here and by the automatic clear after a failed erase
                     `FCI_OP_CLEAR_STATUS: next_cyc_data = `FCI_CMD_CLEAR_STATUS;
                     // R18 R19 identification by command
                     `FCI_OP_READ_ID: next_cyc_data = `FCI_CMD_READ_ID;
                     // R13 erase setup at block address
                     `FCI_OP_ERASE: next_cyc_data = `FCI_CMD_ERASE_SETUP;
                     // R21 program setup
                     `FCI_OP_PROGRAM: next_cyc_data = `FCI_CMD_PROGRAM_SETUP;
                     // R22 suspend and resume
                     `FCI_OP_SUSPEND: next_cyc_data = `FCI_CMD_SUSPEND;
                     `FCI_OP_RESUME: next_cyc_data = `FCI_CMD_CONFIRM;
                     default: begin
                        // R02 plain read in the current mode
                        next_cyc_write = 1'b0;
                        next_cyc_data = 8'h00;
                     end
                  endcase
               end
            end
         end
         fci_pkg::FCI_SQ_FIRST: begin
            if (cyc_done) begin
               next_sq = fci_pkg::FCI_SQ_IDLE;
               case (op)
                  `FCI_OP_READ: begin
                     next_rbyte = cyc_rdata;
                     if (mode == fci_pkg::FCI_MODE_STATUS) begin
                        next_dev_status = cyc_rdata;
                     end
                  end
                  `FCI_OP_READ_ARRAY: next_mode = fci_pkg::FCI_MODE_ARRAY;
                  `FCI_OP_READ_STATUS: next_mode = fci_pkg::FCI_MODE_STATUS;
                  // R20 stays until next command
                  `FCI_OP_READ_ID: next_mode = fci_pkg::FCI_MODE_ID;
                  `FCI_OP_CLEAR_STATUS: next_supply_lock = 1'b0;
                  `FCI_OP_ERASE, `FCI_OP_PROGRAM: begin
                     // R13 R21 second write, same address register
                     next_cyc_start = 1'b1;
                     next_cyc_write = 1'b1;
                     next_cyc_data = (op == `FCI_OP_ERASE) ? `FCI_CMD_CONFIRM : wdata_r;
                     next_sq = fci_pkg::FCI_SQ_SECOND;
                  end
                  default: begin
                     // suspend and resume: poll until the sequencer settles
                     next_mode = fci_pkg::FCI_MODE_STATUS;
                     next_cyc_start = 1'b1;
                     next_cyc_write = 1'b0;
                     next_sq = fci_pkg::FCI_SQ_POLL;
                  end
               endcase
            end
         end
         fci_pkg::FCI_SQ_SECOND: begin
            if (cyc_done) begin
               // R15 device now answers with status
               next_mode = fci_pkg::FCI_MODE_STATUS;
               next_cyc_start = 1'b1;
               next_cyc_write = 1'b0;
               next_sq = fci_pkg::FCI_SQ_POLL;
            end
         end
         fci_pkg::FCI_SQ_POLL: begin
            if (cyc_done) begin
               next_dev_status = cyc_rdata;
               // R16 R23 ready bit ends the wait
               if (cyc_rdata[`FCI_SR_READY]) begin
                  next_sq = fci_pkg::FCI_SQ_IDLE;
                  if (cyc_rdata[`FCI_SR_SUPPLY_LOW]) begin
                     next_supply_lock = 1'b1;
                  end
                  // R17 R24 clear after a failed or improper erase
                  if (op == `FCI_OP_ERASE && cyc_rdata[`FCI_SR_ERASE_FAIL]) begin
                     next_cyc_start = 1'b1;
                     next_cyc_write = 1'b1;
                     next_cyc_data = `FCI_CMD_CLEAR_STATUS;
                     next_sq = fci_pkg::FCI_SQ_AUTOCLR;
                  end
               end else begin
                  next_cyc_start = 1'b1;
               end
            end
         end
         fci_pkg::FCI_SQ_AUTOCLR: begin
            if (cyc_done) begin
               next_supply_lock = 1'b0;
               next_sq = fci_pkg::FCI_SQ_IDLE;
            end
         end
         fci_pkg::FCI_SQ_PD: begin
            if (!pwrdn) begin
               next_rp_n = 1'b1;
               next_wake_cnt = 5'(WAKE_CYC);
               next_sq = fci_pkg::FCI_SQ_WAKE;
            end
         end
         fci_pkg::FCI_SQ_WAKE: begin
            if (wake_cnt != 5'h00) begin
               next_wake_cnt = wake_cnt - 5'h01;
            end else begin
               // R01 wake into array reads
               next_mode = fci_pkg::FCI_MODE_ARRAY;
               next_sq = fci_pkg::FCI_SQ_IDLE;
            end
         end
         default: next_sq = fci_pkg::FCI_SQ_IDLE;
      endcase
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         sq <= fci_pkg::FCI_SQ_IDLE;
         mode <= fci_pkg::FCI_MODE_ARRAY;
         op <= 4'h0;
         cyc_start <= 1'b0;
         cyc_write <= 1'b0;
         cyc_data <= 8'h00;
         cyc_addr <= 17'h00000;
         dev_status <= `FCI_RST_STATUS_BYTE;
         rbyte <= 8'h00;
         refused <= 1'b0;
         supply_lock <= 1'b0;
         wake_cnt <= 5'h00;
         rp_n <= 1'b1;
      end else begin
         sq <= next_sq;
         mode <= next_mode;
         op <= next_op;
         cyc_start <= next_cyc_start;
         cyc_write <= next_cyc_write;
         cyc_data <= next_cyc_data;
         cyc_addr <= next_cyc_addr;
         dev_status <= next_dev_status;
         rbyte <= next_rbyte;
         refused <= next_refused;
         supply_lock <= next_supply_lock;
         wake_cnt <= next_wake_cnt;
         rp_n <= next_rp_n;
      end
   end

endmodule : fci_ctrl

// >>> verilog/fci_pkg.sv
// Purpose: types shared by the flash command interface controller
// Assumes: nothing
// Notes:   constants live in fci_regs.svh
package fci_pkg;

   typedef struct packed {
      logic [16:0] addr;
      logic [7:0] dq_out;
      logic dq_oe;
      logic ce_n;
      logic oe_n;
      logic we_n;
   } fci_pins_t;

   typedef enum logic [1:0] {
      FCI_MODE_ARRAY,
      FCI_MODE_STATUS,
      FCI_MODE_ID
   } fci_mode_t;

   typedef enum logic [1:0] {
      FCI_CY_IDLE,
      FCI_CY_SETUP,
      FCI_CY_STROBE,
      FCI_CY_RECOVER
   } fci_cy_state_t;

   typedef enum logic [2:0] {
      FCI_SQ_IDLE,
      FCI_SQ_FIRST,
      FCI_SQ_SECOND,
      FCI_SQ_POLL,
      FCI_SQ_AUTOCLR,
      FCI_SQ_PD,
      FCI_SQ_WAKE
   } fci_sq_state_t;

endpackage : fci_pkg

// >>> verilog/fci_regs.svh
// Purpose: register map, command bytes, field positions and timing figures of the
//          flash command interface controller
// Assumes: 25 MHz controller clock
// Notes: times in ns; cycle counts derived where used
`ifndef FCI_REGS_SVH
`define FCI_REGS_SVH

// software register byte addresses
`define FCI_REG_CMD 8'h00
`define FCI_REG_ADDR 8'h04
`define FCI_REG_WDATA 8'h08
`define FCI_REG_CTRL 8'h0C
`define FCI_REG_STATUS 8'h10
`define FCI_REG_RDATA 8'h14

// reset values
`define FCI_RST_ADDR 17'h00000
`define FCI_RST_WDATA 8'h00
`define FCI_RST_STATUS_BYTE 8'h00

// control register fields
`define FCI_CTRL_PWRDN 0
`define FCI_CTRL_SUPPLY 1

// status register fields
`define FCI_ST_BUSY 0
`define FCI_ST_REFUSED 1
`define FCI_ST_SUPPLY_LOCK 2
`define FCI_ST_MODE_LO 3
`define FCI_ST_MODE_HI 4
`define FCI_ST_DEV_LO 8
`define FCI_ST_DEV_HI 15

// operation codes written to CMD[3:0]
`define FCI_OP_READ_ARRAY 4'h1
`define FCI_OP_READ_STATUS 4'h2
`define FCI_OP_CLEAR_STATUS 4'h3
`define FCI_OP_READ_ID 4'h4
`define FCI_OP_ERASE 4'h5
`define FCI_OP_PROGRAM 4'h6
`define FCI_OP_SUSPEND 4'h7
`define FCI_OP_RESUME 4'h8
`define FCI_OP_READ 4'h9

// command bytes understood by the flash
`define FCI_CMD_READ_ARRAY 8'hFF
`define FCI_CMD_READ_STATUS 8'h70
`define FCI_CMD_CLEAR_STATUS 8'h50
`define FCI_CMD_READ_ID 8'h90
`define FCI_CMD_ERASE_SETUP 8'h20
`define FCI_CMD_CONFIRM 8'hD0
`define FCI_CMD_PROGRAM_SETUP 8'h40
`define FCI_CMD_SUSPEND 8'hB0

// flash status byte bit positions
`define FCI_SR_READY 7
`define FCI_SR_SUSPENDED 6
`define FCI_SR_ERASE_FAIL 5
`define FCI_SR_PROGRAM_FAIL 4
`define FCI_SR_SUPPLY_LOW 3

// timing
`define FCI_CLK_PERIOD_NS 40
`define FCI_T_WP_NS 40
`define FCI_T_WPH_NS 10
`define FCI_T_ACC_NS 150
`define FCI_T_HZ_NS 55
`define FCI_T_WAKE_NS 600

`endif
